// file: rtl/cable_vdo_pkg.sv
// Constants and field checks for the passive cable data object builder
package cable_vdo_pkg;

    // Register byte offsets
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_VDO = 4'hC;

    // Field positions inside the data object (and inside the config register)
    localparam int HW_LSB = 28;
    localparam int FW_LSB = 24;
    localparam int VER_LSB = 21;
    localparam int PLUG_LSB = 18;
    localparam int LAT_LSB = 13;
    localparam int TERM_LSB = 11;
    localparam int VMAX_LSB = 9;
    localparam int CUR_LSB = 5;
    localparam int SPD_LSB = 0;

    localparam logic [2:0] VDO_VER_1_0 = 3'h0;
    localparam logic [1:0] TERM_NO_VCONN = 2'h0;
    // Reserved bits 20, 17, 8:7, 4:3 plus the version field
    localparam logic [31:0] RSVD_MASK = 32'h0012_0198;
    localparam logic [31:0] VER_MASK = 32'h00E0_0000;

    // Control register bits
    localparam int CTRL_CABLE_BIT = 0;
    localparam int CTRL_DISC_ONLY_BIT = 1;
    localparam int CTRL_W = 2;

    // Status: sticky error bits, live error field at STAT_LIVE_LSB
    localparam int ERR_PLUG = 0;
    localparam int ERR_LAT = 1;
    localparam int ERR_TERM = 2;
    localparam int ERR_CUR = 3;
    localparam int ERR_SPD = 4;
    localparam int ERR_W = 5;
    localparam int STAT_LIVE_LSB = 8;

    // Values after reset: Type-C plug, latency under 10 ns, no VCONN, 20 V, 3 A, USB 2.0
    localparam logic [31:0] CFG_RST = 32'h0008_2020;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic plug_ok(input logic [1:0] c);
        return c[1];
    endfunction : plug_ok

    function automatic logic lat_ok(input logic [3:0] c);
        return (c != 4'h0) && (c <= 4'h8);
    endfunction : lat_ok

    function automatic logic term_ok(input logic [1:0] c);
        return !c[1];
    endfunction : term_ok

    function automatic logic cur_ok(input logic [1:0] c);
        return (c == 2'h1) || (c == 2'h2);
    endfunction : cur_ok

    function automatic logic spd_ok(input logic [2:0] c);
        return c <= 3'h2;
    endfunction : spd_ok

endpackage : cable_vdo_pkg

// file: rtl/passive_cable_vdo_builder.sv
// Passive cable data object builder with AXI4-Lite configuration port
`timescale 1ns/1ps
// Functional notes
// - The object is offered in the identity response whenever the product type says cable.
// - Bits 31:28 and 27:24 carry the vendor hardware and firmware versions unaltered.
// - The version field 23:21 is always 000b.
// - Bits 20, 17, 8:7 and 4:3 are always zero.
// - Bits 19:18 carry 10b for a Type-C plug, 11b for captive; 00b and 01b are reserved.
// - Bits 16:13 carry latency codes 0001b to 1000b; others are reserved.
// - Bits 12:11 carry 00b without VCONN, 01b with VCONN; 10b and 11b are reserved.
// - A plug that only answers identity discovery reports termination 00b.
// - Bits 10:9 carry the maximum bus voltage, 00b 20 V up to 11b 50 V.
// - Bits 6:5 carry 01b for 3 A and 10b for 5 A; 00b and 11b are reserved.
// - Bits 2:0 carry 000b, 001b or 010b; 011b to 111b are reserved.
module passive_cable_vdo_builder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic id_req,
    output logic id_valid,
    output logic id_include,
    output logic [31:0] id_word,
    output logic cfg_error
);
    import cable_vdo_pkg::*;

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    function automatic logic addr_known(input logic [3:0] a);
        return (a == ADDR_CFG) || (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_VDO);
    endfunction : addr_known

    logic [31:0] cfg_q, cfg_d;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [ERR_W-1:0] err_q, err_d;
    logic [31:0] vdo_live;
    logic [ERR_W-1:0] err_live;

    logic aw_held_q, aw_held_d;
    logic [3:0] aw_addr_q, aw_addr_d;
    logic w_held_q, w_held_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic id_valid_q, id_valid_d;
    logic id_include_q, id_include_d;
    logic [31:0] id_word_q, id_word_d;

    logic do_write;
    logic [ERR_W-1:0] err_clr;

    vdo_pack u_pack (
        .cfg(cfg_q),
        .disc_only(ctrl_q[CTRL_DISC_ONLY_BIT]),
        .vdo(vdo_live),
        .err(err_live)
    );

    // Handshakes close while ce is low, so the master never hands an item to frozen state
    assign s_axi_awready = ce && !aw_held_q && !bvalid_q;
    assign s_axi_wready = ce && !w_held_q && !bvalid_q;
    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_bvalid = ce && bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = ce && rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    // Write channel: address and data are captured in either order
    always_comb begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d = w_held_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q <= w_held_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // Read channel: data one cycle after the address is taken
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (s_axi_araddr)
                ADDR_CFG: rdata_d = cfg_q;
                ADDR_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
                ADDR_STATUS: begin
                    rdata_d[ERR_W-1:0] = err_q;
                    rdata_d[STAT_LIVE_LSB +: ERR_W] = err_live;
                end
                ADDR_VDO: rdata_d = vdo_live;
                default: rresp_d = RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Configuration, sticky errors and the identity response port
    always_comb begin
        cfg_d = cfg_q;
        ctrl_d = ctrl_q;
        err_clr = '0;
        if (do_write) begin
            unique case (aw_addr_q)
                ADDR_CFG: cfg_d = strb_merge(cfg_q, w_data_q, w_strb_q);
                ADDR_CTRL: begin
                    if (w_strb_q[0]) begin
                        ctrl_d = w_data_q[CTRL_W-1:0];
                    end
                end
                ADDR_STATUS: begin
                    if (w_strb_q[0]) begin
                        err_clr = w_data_q[ERR_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        // A live error in the clearing cycle keeps its flag set
        err_d = (err_q & ~err_clr) | err_live;
        id_valid_d = id_req;
        id_word_d = id_req ? vdo_live : id_word_q;
        id_include_d = id_req ? ctrl_q[CTRL_CABLE_BIT] : id_include_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= CFG_RST;
            ctrl_q <= CTRL_RST;
            err_q <= '0;
            id_valid_q <= 1'b0;
            id_word_q <= 32'h0000_0000;
            id_include_q <= 1'b0;
        end else if (ce) begin
            cfg_q <= cfg_d;
            ctrl_q <= ctrl_d;
            err_q <= err_d;
            id_valid_q <= id_valid_d;
            id_word_q <= id_word_d;
            id_include_q <= id_include_d;
        end
    end

    assign id_valid = id_valid_q;
    assign id_word = id_word_q;
    assign id_include = id_include_q;
    assign cfg_error = |err_q;

    // Checks on the emitted word and its cause
    sequence id_taken_s;
        ce && id_req;
    endsequence

    sequence id_shown_s;
        ##1 id_valid;
    endsequence

    id_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |-> id_shown_s ##0 (id_include == $past(ctrl_q[CTRL_CABLE_BIT])))
        else $error("identity answer missing or wrong include");
    id_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |=> (id_word[31:24] == $past(cfg_q[31:24])))
        else $error("vendor versions altered");
    version_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_valid |-> (id_word[VER_LSB +: 3] == VDO_VER_1_0))
        else $error("version field not 000b");
    reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_valid |-> ((id_word & RSVD_MASK) == 32'h0000_0000))
        else $error("reserved bit set");
    plug_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !plug_ok(cfg_q[PLUG_LSB +: 2])) |=> err_q[ERR_PLUG])
        else $error("reserved plug code not flagged");
    lat_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !lat_ok(cfg_q[LAT_LSB +: 4])) |=> err_q[ERR_LAT])
        else $error("reserved latency not flagged");
    term_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !term_ok(vdo_live[TERM_LSB +: 2])) |=> err_q[ERR_TERM])
        else $error("reserved termination not flagged");
    disc_term_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (id_taken_s and ctrl_q[CTRL_DISC_ONLY_BIT]) |=> (id_word[TERM_LSB +: 2] == TERM_NO_VCONN))
        else $error("discovery-only plug reports VCONN");
    vmax_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |=> (id_word[VMAX_LSB +: 2] == $past(cfg_q[VMAX_LSB +: 2])))
        else $error("voltage field altered");
    cur_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !cur_ok(cfg_q[CUR_LSB +: 2])) |=> err_q[ERR_CUR])
        else $error("reserved current not flagged");
    spd_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !spd_ok(cfg_q[SPD_LSB +: 3])) |=> err_q[ERR_SPD])
        else $error("reserved speed not flagged");
    err_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && (err_q != '0) && !do_write) |=> (err_q == ($past(err_q) | $past(err_live))))
        else $error("sticky error lost");
    err_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && do_write && (aw_addr_q == ADDR_STATUS) && w_strb_q[0]) |=>
            ((err_q & $past(w_data_q[ERR_W-1:0]) & ~$past(err_live)) == '0))
        else $error("cleared error flag stayed set");
    id_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(ce && id_req) |=> ($stable(id_word) && $stable(id_include)))
        else $error("identity word changed without a request");
    id_frozen_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ce |=> ($stable(id_valid) && $stable(err_q)))
        else $error("state moved while frozen");
    plug_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |=> (id_word[PLUG_LSB +: 2] == $past(cfg_q[PLUG_LSB +: 2])))
        else $error("plug field altered");
    lat_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |=> (id_word[LAT_LSB +: 4] == $past(cfg_q[LAT_LSB +: 4])))
        else $error("latency field altered");
    term_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (id_taken_s and !ctrl_q[CTRL_DISC_ONLY_BIT]) |=> (id_word[TERM_LSB +: 2] == $past(cfg_q[TERM_LSB +: 2])))
        else $error("termination field altered");
    cur_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |=> (id_word[CUR_LSB +: 2] == $past(cfg_q[CUR_LSB +: 2])))
        else $error("current field altered");
    spd_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        id_taken_s |=> (id_word[SPD_LSB +: 3] == $past(cfg_q[SPD_LSB +: 3])))
        else $error("signalling field altered");

endmodule : passive_cable_vdo_builder

// file: rtl/vdo_pack.sv
// Packs the stored configuration into the cable data object and flags reserved codes
`timescale 1ns/1ps
module vdo_pack (
    input wire logic [31:0] cfg,
    input wire logic disc_only,
    output logic [31:0] vdo,
    output logic [cable_vdo_pkg::ERR_W-1:0] err
);
    import cable_vdo_pkg::*;

    always_comb begin
        // Vendor fields, plug, latency, voltage, current, speed pass unaltered
        vdo = cfg & ~(RSVD_MASK | VER_MASK);
        vdo[VER_LSB +: 3] = VDO_VER_1_0;
        if (disc_only) begin
            vdo[TERM_LSB +: 2] = TERM_NO_VCONN;
        end
        err = '0;
        // Reserved codes are still emitted; the configuring agent must fix them
        err[ERR_PLUG] = !plug_ok(cfg[PLUG_LSB +: 2]);
        err[ERR_LAT] = !lat_ok(cfg[LAT_LSB +: 4]);
        err[ERR_TERM] = !term_ok(vdo[TERM_LSB +: 2]);
        err[ERR_CUR] = !cur_ok(cfg[CUR_LSB +: 2]);
        err[ERR_SPD] = !spd_ok(cfg[SPD_LSB +: 3]);
    end

endmodule : vdo_pack

// file: tb/host_port_model.sv
// Host port model: asks for the identity object and captures each answer
`timescale 1ns/1ps
module host_port_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ask,
    input wire logic [1:0] dly,
    output logic id_req,
    input wire logic id_valid,
    input wire logic id_include,
    input wire logic [31:0] id_word,
    output logic got,
    output logic [32:0] got_word
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    // A new ask reloads the wait, so only zero-wait asks can go back to back
    always_comb begin
        cnt_d = ask ? {1'b0, dly} + 3'h1 : (cnt_q == 3'h0 ? 3'h0 : cnt_q - 3'h1);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 3'h0;
            id_req <= 1'b0;
            got <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            id_req <= (cnt_q == 3'h1);
            got <= id_valid;
        end
        got_word <= {id_include, id_word};
    end
endmodule : host_port_model

// file: tb/test_passive_cable_vdo_builder.sv
// Self-checking bench for the passive cable data object builder
`timescale 1ns/1ps
module test_passive_cable_vdo_builder;
    import cable_vdo_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic ask = 1'b0;
    logic [1:0] dly = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic id_req, id_valid, id_include, cfg_error, got;
    logic [1:0] s_axi_bresp, s_axi_rresp, ctl;
    logic [31:0] s_axi_rdata, id_word, cfg;
    logic [32:0] got_word;
    logic [32:0] idq[$];
    logic [33:0] rdq[$];
    logic [1:0] bq[$];
    logic ce_rand = 1'b0;
    int miscompares = 0;
    int comparisons = 0;
    int seed = 32'hFE982F37;
    int lsb[5] = '{PLUG_LSB, LAT_LSB, TERM_LSB, CUR_LSB, SPD_LSB};
    int wd[5] = '{2, 4, 2, 2, 3};

    initial begin
        forever #4 aclk = ~aclk;
    end

    // Random stalls only during register traffic; a single-cycle identity request needs ce high
    always @(posedge aclk) begin
        ce <= !ce_rand || (($random(seed) & 3) != 0);
    end

    passive_cable_vdo_builder dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .id_req(id_req),
        .id_valid(id_valid), .id_include(id_include), .id_word(id_word), .cfg_error(cfg_error)
    );

    host_port_model host (
        .aclk(aclk), .aresetn(aresetn), .ask(ask), .dly(dly), .id_req(id_req), .id_valid(id_valid),
        .id_include(id_include), .id_word(id_word), .got(got), .got_word(got_word)
    );

    function automatic logic [31:0] expw(input logic [31:0] c, input logic d);
        logic [31:0] w;
        // Keeps 31:24, 19:18, 16:9, 6:5 and 2:0; version and reserved bits read as zero
        w = c & 32'hFF0D_FE67;
        if (d) begin
            w[12:11] = TERM_NO_VCONN;
        end
        return w;
    endfunction : expw

    function automatic bit bad(input int f, input int c);
        case (f)
            0: return c < 2;
            1: return c == 0 || c > 8;
            2: return c > 1;
            3: return c == 0 || c == 3;
            default: return c > 2;
        endcase
    endfunction : bad

    task automatic cmp_id(input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD id_word exp %h got %h", e, g);
        end
    endtask : cmp_id

    task automatic cmp_reg(input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD rdata exp %h got %h", e, g);
        end
    endtask : cmp_reg

    task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD bresp exp %h got %h", e, g);
        end
    endtask : cmp_resp

    task automatic cmp_flag(input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD cfg_error exp %b got %b", e, g);
        end
    endtask : cmp_flag

    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Address and data are offered together; each drops once its own ready was seen
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        bq.push_back((a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!(aw && w));
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        rdq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Two asks in a row give back-to-back requests only with zero wait
    task automatic req(input int n, input logic [1:0] d, input logic [32:0] e);
        repeat (n) begin
            idq.push_back(e);
            @(posedge aclk);
            ask <= 1'b1;
            dly <= d;
        end
        @(posedge aclk);
        ask <= 1'b0;
        while (idq.size() != 0) @(posedge aclk);
    endtask : req

    always @(posedge aclk) begin
        if (got) cmp_id(idq.pop_front(), got_word);
        if (s_axi_rvalid && s_axi_rready) cmp_reg(rdq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) cmp_resp(bq.pop_front(), s_axi_bresp);
    end

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CFG, {RESP_OKAY, CFG_RST});
        rd(ADDR_CTRL, {RESP_OKAY, 30'h0, CTRL_RST});
        rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
        rd(ADDR_VDO, {RESP_OKAY, expw(CFG_RST, 1'b0)});
        rd(4'h2, {RESP_SLVERR, 32'h0});
        wr(4'h6, 32'hFFFF_FFFF);
        rd(ADDR_CFG, {RESP_OKAY, CFG_RST});
        req(1, 2'h0, {1'b1, expw(CFG_RST, 1'b0)});
        for (int i = 0; i < 24; i++) begin
            cfg = $random(seed);
            ctl = 2'($random(seed));
            cfg[19:18] = 2'(2 + i % 2);
            cfg[16:13] = 4'(1 + i % 8);
            cfg[12:11] = 2'(i % 2);
            cfg[10:9] = 2'(i % 4);
            cfg[6:5] = 2'(1 + i % 2);
            cfg[2:0] = 3'(i % 3);
            ce_rand <= 1'b1;
            wr(ADDR_CFG, cfg);
            wr(ADDR_CTRL, {30'h0, ctl});
            rd(ADDR_CTRL, {RESP_OKAY, 30'h0, ctl});
            rd(ADDR_VDO, {RESP_OKAY, expw(cfg, ctl[1])});
            ce_rand <= 1'b0;
            req((i % 4 == 0) ? 2 : 1, 2'(i % 4), {ctl[0], expw(cfg, ctl[1])});
            cmp_flag(1'b0, cfg_error);
        end
        wr(ADDR_CTRL, 32'h1);
        for (int f = 0; f < 5; f++) begin
            for (int c = 0; c < (1 << wd[f]); c++) begin
                if (bad(f, c)) begin
                    cfg = CFG_RST & ~(((32'h1 << wd[f]) - 32'h1) << lsb[f]);
                    cfg = cfg | (32'(c) << lsb[f]);
                    wr(ADDR_CFG, cfg);
                    req(1, 2'h3, {1'b1, expw(cfg, 1'b0)});
                    rd(ADDR_STATUS, {RESP_OKAY, 32'h101 << f});
                    cmp_flag(1'b1, cfg_error);
                    wr(ADDR_CFG, CFG_RST);
                    wr(ADDR_STATUS, 32'h1F);
                    rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
                    cmp_flag(1'b0, cfg_error);
                end
            end
        end
        repeat (4) @(posedge aclk);
        report_and_stop();
    end
endmodule : test_passive_cable_vdo_builder
